// >>> logic/async_timer_counter_8bit.sv
// 8-bit timer/counter with two compare channels and waveform outputs
// assumes all inputs except crystal_pin_in synchronous to ref_clk; crystal_pin_in is sampled and edge detected
`timescale 1ns/1ps
module async_timer_counter_8bit #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // configuration
  input  wire logic         timer_power_reduction,
  input  wire logic         async_clock_select,
  input  wire logic [2:0]   clock_select_field,
  input  wire logic [2:0]   waveform_mode_field,
  input  wire logic [1:0]   compare_output_mode_a,
  input  wire logic [1:0]   compare_output_mode_b,
  // crystal pins
  input  wire logic         crystal_pin_in,
  output logic              crystal_pin_out,
  // counter access
  input  wire logic         counter_wr_en,
  input  wire logic [W-1:0] counter_wr_data,
  output logic [W-1:0]      counter_value,
  // compare register access
  input  wire logic         compare_a_wr_en,
  input  wire logic         compare_b_wr_en,
  input  wire logic [W-1:0] compare_wr_data,
  output logic [W-1:0]      compare_value_a,
  output logic [W-1:0]      compare_value_b,
  // force strobes
  input  wire logic         force_compare_strobe_a,
  input  wire logic         force_compare_strobe_b,
  // flags, masks, requests
  input  wire logic         flag_wr_en,
  input  wire logic [2:0]   flag_wr_data,
  input  wire logic [2:0]   irq_ack,
  input  wire logic [2:0]   interrupt_mask_register,
  output logic [2:0]        interrupt_flag_register,
  output logic [2:0]        irq_req,
  // waveform and pins
  input  wire logic         port_data_a,
  input  wire logic         port_dir_a,
  input  wire logic         port_data_b,
  input  wire logic         port_dir_b,
  output logic              waveform_out_a,
  output logic              waveform_out_b,
  output logic              pin_a_out,
  output logic              pin_a_oe_b,
  output logic              pin_b_out,
  output logic              pin_b_oe_b
);

  function automatic logic [1:0] out_action(input logic [1:0] com, input logic cur);
    // returns {change, new level} for a non-pwm match
    unique case (com)
      timer_pkg::COM_OFF:    out_action = 2'h0;
      timer_pkg::COM_TOGGLE: out_action = {1'b1, ~cur};
      timer_pkg::COM_CLEAR:  out_action = 2'h2;
      timer_pkg::COM_SET:    out_action = 2'h3;
    endcase
  endfunction : out_action

  function automatic logic tap_hit(input logic [2:0] cs, input logic [9:0] pre);
    unique case (cs)
      timer_pkg::CS_STOP:    tap_hit = 1'b0;
      timer_pkg::CS_DIV1:    tap_hit = 1'b1;
      timer_pkg::CS_DIV8:    tap_hit = &pre[2:0];
      timer_pkg::CS_DIV32:   tap_hit = &pre[4:0];
      timer_pkg::CS_DIV64:   tap_hit = &pre[5:0];
      timer_pkg::CS_DIV128:  tap_hit = &pre[6:0];
      timer_pkg::CS_DIV256:  tap_hit = &pre[7:0];
      timer_pkg::CS_DIV1024: tap_hit = &pre[9:0];
    endcase
  endfunction : tap_hit

  // crystal sampling: first stage feeds only the second
  logic xtal_s1;
  logic xtal_s2;
  logic xtal_s3;
  logic [timer_pkg::PRE_W-1:0] prescale;
  logic [W-1:0] active_a;
  logic [W-1:0] active_b;
  logic [W-1:0] buffer_a;
  logic [W-1:0] buffer_b;
  logic         block;
  timer_pkg::dir_t dir;

  wire enabled   = ~timer_power_reduction;
  wire src_pulse = async_clock_select ? (xtal_s2 & ~xtal_s3) : 1'b1;
  wire tick      = enabled & src_pulse & tap_hit(clock_select_field, prescale);
  wire cnt_wr    = enabled & counter_wr_en;

  wire mode_fast = (waveform_mode_field == timer_pkg::MODE_FAST_MAX) |
                   (waveform_mode_field == timer_pkg::MODE_FAST_A);
  wire mode_pc   = (waveform_mode_field == timer_pkg::MODE_PC_MAX) |
                   (waveform_mode_field == timer_pkg::MODE_PC_A);
  wire mode_ctc  = waveform_mode_field == timer_pkg::MODE_CTC;
  wire pwm       = mode_fast | mode_pc;
  wire top_is_a  = (waveform_mode_field == timer_pkg::MODE_FAST_A) |
                   (waveform_mode_field == timer_pkg::MODE_PC_A);
  wire [W-1:0] top_val = top_is_a ? active_a : timer_pkg::MAX;
  wire at_top    = counter_value == top_val;
  wire at_bottom = counter_value == timer_pkg::BOTTOM;

  wire hit_a = tick & ~block & (counter_value == active_a);
  wire hit_b = tick & ~block & (counter_value == active_b);

  // counter next value
  logic [W-1:0] next_count;
  timer_pkg::dir_t next_dir;
  logic         ovf_set;
  always_comb begin
    next_count = counter_value + W'(1);
    next_dir   = dir;
    ovf_set    = 1'b0;
    if (mode_pc) begin
      if (dir == timer_pkg::DIR_UP && at_top) begin
        next_dir   = timer_pkg::DIR_DOWN;
        next_count = counter_value - W'(1);
      end else if (dir == timer_pkg::DIR_DOWN && at_bottom) begin
        next_dir   = timer_pkg::DIR_UP;
        ovf_set    = 1'b1;
      end else if (dir == timer_pkg::DIR_DOWN) begin
        next_count = counter_value - W'(1);
      end
    end else if (mode_fast) begin
      if (at_top) begin
        next_count = timer_pkg::BOTTOM;
        ovf_set    = 1'b1;
      end
    end else if (mode_ctc && counter_value == active_a) begin
      next_count = timer_pkg::BOTTOM;
      ovf_set    = counter_value == timer_pkg::MAX;
    end else begin
      ovf_set    = counter_value == timer_pkg::MAX;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_s3 <= 1'b0;
      crystal_pin_out <= 1'b1;
    end else begin
      xtal_s1 <= crystal_pin_in;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
      crystal_pin_out <= ~xtal_s2;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale <= '0;
    end else if (enabled && src_pulse) begin
      prescale <= prescale + timer_pkg::PRE_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      counter_value <= timer_pkg::CNT_RESET;
      dir           <= timer_pkg::DIR_UP;
    end else if (cnt_wr) begin
      counter_value <= counter_wr_data;
    end else if (tick) begin
      counter_value <= next_count;
      dir           <= mode_pc ? next_dir : timer_pkg::DIR_UP;
    end
  end

  // a write arms the block until the next timer tick has passed
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      block <= 1'b0;
    end else if (cnt_wr) begin
      block <= 1'b1;
    end else if (tick) begin
      block <= 1'b0;
    end
  end

  // buffer update at top for both pwm kinds: end of slope / turnaround
  wire load_active = tick & pwm & at_top & (!mode_pc || dir == timer_pkg::DIR_UP);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      buffer_a <= timer_pkg::CMP_RESET;
      buffer_b <= timer_pkg::CMP_RESET;
      active_a <= timer_pkg::CMP_RESET;
      active_b <= timer_pkg::CMP_RESET;
    end else begin
      if (enabled && compare_a_wr_en) buffer_a <= compare_wr_data;
      if (enabled && compare_b_wr_en) buffer_b <= compare_wr_data;
      if (!pwm && enabled && compare_a_wr_en) begin
        active_a <= compare_wr_data;
      end else if (!pwm || load_active) begin
        active_a <= buffer_a;
      end
      if (!pwm && enabled && compare_b_wr_en) begin
        active_b <= compare_wr_data;
      end else if (!pwm || load_active) begin
        active_b <= buffer_b;
      end
    end
  end
  assign compare_value_a = pwm ? buffer_a : active_a;
  assign compare_value_b = pwm ? buffer_b : active_b;

  // waveform generator, output mode read live every cycle
  logic next_wave_a;
  logic next_wave_b;
  function automatic logic wave_next(input logic [1:0] com, input logic cur, input logic hit,
                                     input logic frc, input logic pwm_m, input logic fast,
                                     input logic wrap, input logic up, input logic chan_a,
                                     input logic top_a);
    logic [1:0] act;
    act = out_action(com, cur);
    wave_next = cur;
    if (!pwm_m) begin
      if ((hit || frc) && act[1]) wave_next = act[0];
    end else if (com == timer_pkg::COM_TOGGLE) begin
      if (hit && chan_a && top_a) wave_next = ~cur;
    end else if (com != timer_pkg::COM_OFF) begin
      if (fast && hit) wave_next = com[0];
      else if (fast && wrap) wave_next = ~com[0];
      else if (hit) wave_next = up ? com[0] : ~com[0];
    end
  endfunction : wave_next

  wire wrap = tick & mode_fast & at_top;
  wire up   = dir == timer_pkg::DIR_UP;
  assign next_wave_a = wave_next(compare_output_mode_a, waveform_out_a, hit_a,
                                 force_compare_strobe_a & enabled, pwm, mode_fast, wrap, up,
                                 1'b1, top_is_a);
  assign next_wave_b = wave_next(compare_output_mode_b, waveform_out_b, hit_b,
                                 force_compare_strobe_b & enabled, pwm, mode_fast, wrap, up,
                                 1'b0, top_is_a);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      waveform_out_a <= 1'b0;
      waveform_out_b <= 1'b0;
    end else begin
      waveform_out_a <= next_wave_a;
      waveform_out_b <= next_wave_b;
    end
  end

  // port override and pin direction
  assign pin_a_out  = (compare_output_mode_a != timer_pkg::COM_OFF) ? waveform_out_a
                                                                    : port_data_a;
  assign pin_b_out  = (compare_output_mode_b != timer_pkg::COM_OFF) ? waveform_out_b
                                                                    : port_data_b;
  assign pin_a_oe_b = ~port_dir_a;
  assign pin_b_oe_b = ~port_dir_b;

  // flags: hardware set wins over any clear in the same cycle
  wire [2:0] flag_set = {hit_b, hit_a, tick & ovf_set & ~cnt_wr};
  wire [2:0] flag_clr = irq_ack | (flag_wr_en ? flag_wr_data : 3'h0);
  logic [2:0] next_flags;
  assign next_flags = flag_set | (interrupt_flag_register & ~flag_clr);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_flag_register <= timer_pkg::FLAG_RESET;
    end else begin
      interrupt_flag_register <= next_flags;
    end
  end
  assign irq_req = interrupt_flag_register & interrupt_mask_register;

  // checks
  a_write_wins: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cnt_wr |=> counter_value == $past(counter_wr_data))
    else $error("counter write did not prevail");
  a_stop_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clock_select_field == timer_pkg::CS_STOP && !counter_wr_en) |=> $stable(counter_value))
    else $error("counter moved while stopped");
  a_power_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    timer_power_reduction |=> $stable(counter_value) && !$rose(interrupt_flag_register[0]))
    else $error("timer active while powered down");
  a_match_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    hit_a |=> interrupt_flag_register[timer_pkg::FLAG_CMP_A])
    else $error("compare A flag not set after match");
  a_block_next: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cnt_wr ##1 (tick && !cnt_wr) |=> !$rose(interrupt_flag_register[timer_pkg::FLAG_CMP_A])
      && !$rose(interrupt_flag_register[timer_pkg::FLAG_CMP_B]))
    else $error("match not blocked after counter write");
  a_block_tick: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (block && tick && !cnt_wr) |=> !$rose(interrupt_flag_register[timer_pkg::FLAG_CMP_A])
      && !$rose(interrupt_flag_register[timer_pkg::FLAG_CMP_B]))
    else $error("match seen in blocked tick");
  a_ctc_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mode_ctc && tick && !cnt_wr && counter_value == active_a) |=> counter_value == 8'h00)
    else $error("ctc did not clear on compare A");
  a_normal_wrap: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (waveform_mode_field == timer_pkg::MODE_NORMAL && tick && !cnt_wr && counter_value == 8'hFF)
    |=> counter_value == 8'h00 && interrupt_flag_register[timer_pkg::FLAG_OVF])
    else $error("normal mode wrap or overflow wrong");
  a_clear_one: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (flag_wr_en && flag_wr_data[timer_pkg::FLAG_CMP_B] && !hit_b)
    |=> !interrupt_flag_register[timer_pkg::FLAG_CMP_B])
    else $error("write one did not clear flag");
  a_zero_keeps: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (flag_wr_en && !flag_wr_data[timer_pkg::FLAG_CMP_A] && !irq_ack[timer_pkg::FLAG_CMP_A]
     && interrupt_flag_register[timer_pkg::FLAG_CMP_A])
    |=> interrupt_flag_register[timer_pkg::FLAG_CMP_A])
    else $error("write zero disturbed flag");
  a_force_noflag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (force_compare_strobe_a && !hit_a && !pwm && !interrupt_flag_register[timer_pkg::FLAG_CMP_A])
    |=> !interrupt_flag_register[timer_pkg::FLAG_CMP_A])
    else $error("force strobe set a flag");
  a_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    irq_req == (interrupt_flag_register & interrupt_mask_register))
    else $error("interrupt request not gated by mask");

  c_ctc_wrap:  cover property (@(posedge ref_clk) disable iff (!rst_b)
    mode_ctc && hit_a ##1 counter_value == 8'h00);
  c_fast_wrap: cover property (@(posedge ref_clk) disable iff (!rst_b) wrap);
  c_pc_turn:   cover property (@(posedge ref_clk) disable iff (!rst_b)
    mode_pc && tick && dir == timer_pkg::DIR_DOWN && at_bottom);
  c_blocked:   cover property (@(posedge ref_clk) disable iff (!rst_b)
    block && tick && counter_value == active_a);

endmodule : async_timer_counter_8bit

// >>> shared/timer_pkg.sv
// constants, codes and types for the 8-bit compare timer
// assumes one 50 MHz clock; all configuration arrives as plain ports
package timer_pkg;
  localparam int        CNT_W       = 8;
  localparam int        PRE_W       = 10;
  localparam logic [7:0] BOTTOM     = 8'h00;
  localparam logic [7:0] MAX        = 8'hFF;
  localparam logic [7:0] CNT_RESET  = 8'h00;
  localparam logic [7:0] CMP_RESET  = 8'h00;
  // waveform mode field codes
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_PC_MAX  = 3'h1;
  localparam logic [2:0] MODE_CTC     = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_PC_A    = 3'h5;
  localparam logic [2:0] MODE_FAST_A  = 3'h7;
  // clock select field codes
  localparam logic [2:0] CS_STOP  = 3'h0;
  localparam logic [2:0] CS_DIV1  = 3'h1;
  localparam logic [2:0] CS_DIV8  = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV64 = 3'h4;
  localparam logic [2:0] CS_DIV128 = 3'h5;
  localparam logic [2:0] CS_DIV256 = 3'h6;
  localparam logic [2:0] CS_DIV1024 = 3'h7;
  // compare output mode codes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;
  // flag register bit positions
  localparam int FLAG_OVF   = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  localparam logic [2:0] FLAG_RESET = 3'h0;
  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
endpackage : timer_pkg

// >>> tb/crystal_pin_model.sv
// far-side model: a gated watch crystal and the two compare pads
// assumes the bench gates the crystal; both pads carry pull-ups
`timescale 1ns/1ps
module crystal_pin_model #(
  parameter realtime HALF_NS = 131.0
) (
  // crystal
  input  wire logic run,
  output logic      xtal,
  output int        rises,
  // compare pins
  input  wire logic pin_a_out,
  input  wire logic pin_a_oe_b,
  input  wire logic pin_b_out,
  input  wire logic pin_b_oe_b,
  output logic      pad_a,
  output logic      pad_b
);
  // oscillator stands still low outside a run, unrelated in phase to ref_clk
  initial begin
    xtal = 1'b0;
    rises = 0;
    // half-ns offset keeps crystal edges clear of every ref_clk edge
    #(0.5);
    forever begin
      #(HALF_NS);
      xtal = run ? ~xtal : 1'b0;
      if (run && xtal) begin
        rises++;
      end
    end
  end
  // a released pad floats up to the pull-up level
  assign pad_a = pin_a_oe_b ? 1'b1 : pin_a_out;
  assign pad_b = pin_b_oe_b ? 1'b1 : pin_b_out;
endmodule : crystal_pin_model

// >>> tb/async_timer_counter_8bit_tb.sv
// self-checking bench for the 8-bit compare timer
// assumes the crystal_pin_model partner; inputs change on the falling edge
`timescale 1ns/1ps
module async_timer_counter_8bit_tb;
  logic       ref_clk, rst_b, timer_power_reduction, async_clock_select, crystal_pin_in;
  logic       crystal_pin_out, counter_wr_en, compare_a_wr_en, compare_b_wr_en, flag_wr_en;
  logic       force_compare_strobe_a, force_compare_strobe_b, waveform_out_a, waveform_out_b;
  logic       port_data_a, port_dir_a, port_data_b, port_dir_b, pin_a_out, pin_a_oe_b;
  logic       pin_b_out, pin_b_oe_b, xtal_run, pad_a, pad_b;
  logic [1:0] compare_output_mode_a, compare_output_mode_b;
  logic [2:0] clock_select_field, waveform_mode_field, flag_wr_data, irq_ack, irq_req;
  logic [2:0] interrupt_mask_register, interrupt_flag_register;
  logic [7:0] counter_wr_data, counter_value, compare_wr_data, compare_value_a, compare_value_b;
  int         rises, err_count, n_tests;

  async_timer_counter_8bit #(.W(8)) dut_u (.*);
  crystal_pin_model model_u (.run(xtal_run), .xtal(crystal_pin_in), .rises(rises),
    .pin_a_out(pin_a_out), .pin_a_oe_b(pin_a_oe_b), .pin_b_out(pin_b_out),
    .pin_b_oe_b(pin_b_oe_b), .pad_a(pad_a), .pad_b(pad_b));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic wr_cnt(input logic [7:0] v);
    counter_wr_data = v;
    counter_wr_en = 1'b1;
    cyc(1);
    counter_wr_en = 1'b0;
  endtask : wr_cnt
  task automatic wr_cmp(input bit chan_b, input logic [7:0] v);
    compare_wr_data = v;
    compare_a_wr_en = !chan_b;
    compare_b_wr_en = chan_b;
    cyc(1);
    compare_a_wr_en = 1'b0;
    compare_b_wr_en = 1'b0;
  endtask : wr_cmp
  task automatic wr_flags(input logic [2:0] v);
    flag_wr_data = v;
    flag_wr_en = 1'b1;
    cyc(1);
    flag_wr_en = 1'b0;
  endtask : wr_flags
  task automatic wait_cnt(input logic [7:0] v);
    int k;
    k = 0;
    while (counter_value !== v && k < 3000) begin
      cyc(1);
      k++;
    end
    chk(counter_value, v, "counter reach");
  endtask : wait_cnt

  task automatic t_reset;
    chk(counter_value, timer_pkg::CNT_RESET, "counter reset");
    chk(compare_value_a, timer_pkg::CMP_RESET, "compare reset");
    chk(interrupt_flag_register, timer_pkg::FLAG_RESET, "flags reset");
    chk({waveform_out_a, waveform_out_b, crystal_pin_out}, 8'h01, "pins reset");
    wr_cnt(8'h37);
    cyc(10);
    chk(counter_value, 8'h37, "stopped counter");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_prescale;
    int div[8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
    logic [7:0] c0;
    for (int i = 1; i < 8; i++) begin
      clock_select_field = 3'(i);
      cyc(2);
      c0 = counter_value;
      cyc(2 * div[i]);
      chk(counter_value - c0, 8'h02, "ticks per window");
    end
    clock_select_field = timer_pkg::CS_STOP;
    $display("t_prescale done");
  endtask : t_prescale

  task automatic t_overflow;
    clock_select_field = timer_pkg::CS_DIV1;
    wr_cnt(8'hFC);
    chk(counter_value, 8'hFC, "write beats count");
    wr_flags(3'h7);
    wait_cnt(8'h00);
    chk(interrupt_flag_register[0], 1'h1, "overflow flag");
    chk(irq_req[0], 1'h0, "masked request");
    interrupt_mask_register = 3'h1;
    cyc(1);
    chk(irq_req[0], 1'h1, "unmasked request");
    wr_flags(3'h6);
    chk(interrupt_flag_register[0], 1'h1, "zero write keeps");
    cyc(1);
    wr_flags(3'h1);
    chk(interrupt_flag_register[0], 1'h0, "one write clears");
    clock_select_field = timer_pkg::CS_STOP;
    $display("t_overflow done");
  endtask : t_overflow

  task automatic t_compare;
    wr_cmp(1'b0, 8'h20);
    chk(compare_value_a, 8'h20, "direct compare");
    cyc(1);
    wr_cmp(1'b1, 8'h28);
    chk(compare_value_b, 8'h28, "direct compare b");
    wr_cnt(8'h10);
    wr_flags(3'h7);
    clock_select_field = timer_pkg::CS_DIV1;
    wait_cnt(8'h20);
    chk(interrupt_flag_register[1], 1'h0, "flag not early");
    cyc(1);
    chk(interrupt_flag_register[1], 1'h1, "flag a");
    wait_cnt(8'h29);
    chk(interrupt_flag_register[2], 1'h1, "flag b");
    chk(irq_req, 8'h00, "masked compare requests");
    irq_ack = 3'h2;
    cyc(1);
    irq_ack = 3'h0;
    chk(interrupt_flag_register[2:1], 8'h02, "service clear");
    clock_select_field = timer_pkg::CS_STOP;
    wr_cnt(8'h20);
    wr_flags(3'h7);
    cyc(3);
    clock_select_field = timer_pkg::CS_DIV1;
    cyc(4);
    chk(interrupt_flag_register[1], 1'h0, "blocked match");
    clock_select_field = timer_pkg::CS_STOP;
    $display("t_compare done");
  endtask : t_compare

  task automatic t_ctc;
    logic [7:0] mx;
    logic       prev;
    int         tg;
    waveform_mode_field = timer_pkg::MODE_CTC;
    wr_cmp(1'b0, 8'h05);
    compare_output_mode_a = timer_pkg::COM_TOGGLE;
    wr_cnt(8'h00);
    clock_select_field = timer_pkg::CS_DIV1;
    cyc(8);
    mx = 8'h00;
    tg = 0;
    for (int i = 0; i < 18; i++) begin
      prev = waveform_out_a;
      cyc(1);
      tg += (waveform_out_a !== prev);
      mx = (counter_value > mx) ? counter_value : mx;
    end
    chk(mx, 8'h05, "ctc top");
    chk(8'(tg), 8'h03, "ctc toggles");
    clock_select_field = timer_pkg::CS_STOP;
    $display("t_ctc done");
  endtask : t_ctc

  task automatic t_force;
    logic [1:0] cm[4] = '{timer_pkg::COM_SET, timer_pkg::COM_CLEAR, timer_pkg::COM_TOGGLE,
                          timer_pkg::COM_OFF};
    logic       ex[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic [7:0] c0;
    waveform_mode_field = timer_pkg::MODE_NORMAL;
    wr_flags(3'h7);
    c0 = counter_value;
    for (int i = 0; i < 4; i++) begin
      compare_output_mode_a = cm[i];
      compare_output_mode_b = cm[i];
      force_compare_strobe_a = 1'b1;
      force_compare_strobe_b = 1'b1;
      cyc(1);
      force_compare_strobe_a = 1'b0;
      force_compare_strobe_b = 1'b0;
      chk({waveform_out_a, waveform_out_b}, {6'h00, ex[i], ex[i]}, "forced");
      chk(pin_a_out, (cm[i] != 2'h0) ? ex[i] : port_data_a, "override");
      chk(pin_b_out, (cm[i] != 2'h0) ? ex[i] : port_data_b, "override b");
      cyc(1);
    end
    chk(interrupt_flag_register, 8'h00, "force no flag");
    chk(counter_value, c0, "force no clear");
    chk({pad_a, pin_a_oe_b, pad_b, pin_b_oe_b}, 8'h0F, "released pads");
    waveform_mode_field = timer_pkg::MODE_FAST_MAX;
    compare_output_mode_a = timer_pkg::COM_CLEAR;
    force_compare_strobe_a = 1'b1;
    cyc(1);
    force_compare_strobe_a = 1'b0;
    chk(waveform_out_a, 1'h1, "mode change keeps");
    compare_output_mode_a = timer_pkg::COM_SET;
    port_dir_a = 1'b1;
    cyc(1);
    chk({pad_a, pin_a_oe_b}, 8'h02, "driven pad");
    $display("t_force done");
  endtask : t_force

  task automatic t_buffer;
    wr_cnt(8'h02);
    wr_flags(3'h7);
    wr_cmp(1'b0, 8'h30);
    chk(compare_value_a, 8'h30, "buffer readback");
    clock_select_field = timer_pkg::CS_DIV1;
    wait_cnt(8'h07);
    chk(interrupt_flag_register[1], 1'h1, "old active");
    wr_flags(3'h7);
    wait_cnt(8'h40);
    chk(interrupt_flag_register[1], 1'h0, "no early load");
    wait_cnt(8'h20);
    chk(interrupt_flag_register[1], 1'h0, "old value gone");
    wait_cnt(8'h31);
    chk(interrupt_flag_register[1], 1'h1, "loaded at top");
    waveform_mode_field = timer_pkg::MODE_NORMAL;
    timer_power_reduction = 1'b1;
    cyc(1);
    wr_cnt(8'h99);
    chk(counter_value, 8'h31, "frozen");
    timer_power_reduction = 1'b0;
    clock_select_field = timer_pkg::CS_STOP;
    $display("t_buffer done");
  endtask : t_buffer

  task automatic t_async;
    int k;
    cyc(1);
    wr_cnt(8'h00);
    async_clock_select = 1'b1;
    clock_select_field = timer_pkg::CS_DIV1;
    cyc(10);
    chk(counter_value, 8'h00, "no crystal edges");
    xtal_run = 1'b1;
    k = 0;
    while (rises < 8 && k < 500) begin
      cyc(1);
      k++;
    end
    xtal_run = 1'b0;
    cyc(20);
    chk(counter_value, 8'(rises), "crystal ticks");
    chk(crystal_pin_out, 1'h1, "crystal drive idle");
    clock_select_field = timer_pkg::CS_STOP;
    async_clock_select = 1'b0;
    $display("t_async done");
  endtask : t_async

  task automatic stop_test;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end

  initial begin
    {rst_b, timer_power_reduction, async_clock_select, counter_wr_en, xtal_run} = 5'h00;
    {compare_a_wr_en, compare_b_wr_en, flag_wr_en} = 3'h0;
    {force_compare_strobe_a, force_compare_strobe_b} = 2'h0;
    {port_data_a, port_dir_a, port_data_b, port_dir_b} = 4'h0;
    {clock_select_field, waveform_mode_field, flag_wr_data, irq_ack} = 12'h000;
    {compare_output_mode_a, compare_output_mode_b} = 4'h0;
    interrupt_mask_register = 3'h0;
    {counter_wr_data, compare_wr_data} = 16'h0000;
    err_count = 0;
    n_tests = 0;
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    cyc(1);
    t_reset();
    t_prescale();
    t_overflow();
    t_compare();
    t_ctc();
    t_force();
    t_buffer();
    t_async();
    stop_test();
  end
endmodule : async_timer_counter_8bit_tb
